// File: logic/ddrpc_pin_cell.sv
// Purpose: double-data-rate pin cell with capture, launch and oe paths
// Assumes: link clock is clock/2, so each link phase is one cycle
// Notes: registers over ahb-lite; pin inputs pass two flip-flops
//
// What this block does
// - two capture registers sample on rising and falling link edges.
// - a latch holds the high-phase bit; both bits leave on one rising edge.
// - two output registers load on the rising edge; pin runs at twice rate.
// - pin carries first bit while link clock high, second while low.
// - bidirectional mode uses capture and launch paths on one pin.
// - oe register updates on the falling edge, driver off until then.
// - output clock enable defaults high; low makes registers hold.
// - tristate control active high by default, selectable active low.
// - dq, dqs, both clock enables and the oe request can be inverted before use.
// - strobe capture only on dq pins; strobe input only on dqs pins.
// - side-bank mode ignores the read strobe and uses the link clock.
// - output and oe registers share clock and enable; input has own.
// - reset clears to low; the synchronous clear loads the programmable level.
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------------
// two-entry buffer
// ------------------------------------------------------------------
module ddrpc_fifo #(
  parameter int WIDTH = 2,
  parameter int DEPTH = 2
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData,
  output logic [$clog2(DEPTH):0] count
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  wire logic wr = inValid & inReady;
  wire logic rd = outValid & outReady;
  wire logic [AW-1:0] lastPtr = AW'(DEPTH - 1);

  assign inReady = count != ($clog2(DEPTH) + 1)'(DEPTH);
  assign outValid = count != '0;
  assign outData = mem[rp];

  always_ff @(posedge clock) begin
    if (wr) begin
      mem[wp] <= inData;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      wp <= '0;
      rp <= '0;
      count <= '0;
    end else begin
      if (wr) begin
        wp <= (wp == lastPtr) ? '0 : wp + 1'b1;
      end
      if (rd) begin
        rp <= (rp == lastPtr) ? '0 : rp + 1'b1;
      end
      if (wr & ~rd) begin
        count <= count + 1'b1;
      end else if (rd & ~wr) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

// ------------------------------------------------------------------
// pin cell top
// ------------------------------------------------------------------
module ddrpc_pin_cell (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // memory pins
  input wire logic dqIn,
  output logic dqOut,
  output logic dqOeN,
  input wire logic dqsIn,
  output logic linkClk
);
  ddrpc_pkg::ddrpc_ctrl_s ctrl;
  ddrpc_pkg::ddrpc_stat_s stat;
  logic pending;
  logic pendWrite;
  logic pendWord;
  logic [7:0] pendAddr;
  logic overflow;
  logic dqS1;
  logic dqS2;
  logic dqsS1;
  logic dqsS2;
  logic dqsD;
  logic outA;
  logic outB;
  logic riseReg;
  logic fallReg;
  logic heldHigh;
  logic pairReady;
  logic txInReady;
  logic txOutValid;
  logic [1:0] txData;
  logic [1:0] txCount;
  logic rxInReady;
  logic rxOutValid;
  logic [1:0] rxData;
  logic [1:0] rxCount;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire logic addrTake = hsel & hready & (htrans == ddrpc_pkg::HTRANS_NONSEQ);
  wire logic selCtrl = pendAddr == ddrpc_pkg::ADDR_CTRL;
  wire logic selTx = pendAddr == ddrpc_pkg::ADDR_TX;
  wire logic selRx = pendAddr == ddrpc_pkg::ADDR_RX;
  wire logic selStat = pendAddr == ddrpc_pkg::ADDR_STAT;
  wire logic actWr = pending & pendWord & pendWrite;
  wire logic writeTx = actWr & selTx;
  // a full tx buffer stretches the data phase instead of losing the word
  wire logic stallTx = writeTx & ~txInReady;
  wire logic done = pending & ~stallTx;
  wire logic txPush = writeTx & txInReady;
  wire logic rxPop = pending & pendWord & ~pendWrite & selRx & rxOutValid;
  wire logic ctrlWrite = actWr & selCtrl;
  wire ddrpc_pkg::ddrpc_ctrl_s wctrl = ddrpc_pkg::ddrpc_ctrl_s'(hwdata[15:0]);
  wire logic sclrPulse = ctrlWrite & wctrl.sclr;
  wire logic ovfClear = actWr & selStat & hwdata[0];
  wire logic [31:0] readData = selCtrl ? {16'h0000, ctrl} :
                               selRx ? {23'h000000, rxOutValid, 6'h00, rxData} :
                               selStat ? {23'h000000, stat} : 32'h00000000;

  // ----------------------------------------------------------------
  // link timing and launch path
  // ----------------------------------------------------------------
  wire logic goHigh = ctrl.linkEn & ~linkClk;
  wire logic goLow = ctrl.linkEn & linkClk;
  wire logic ceOut = ctrl.outCe ^ ctrl.inv[ddrpc_pkg::INV_CEOUT];
  wire logic loadOut = goHigh & ceOut & txOutValid;
  wire logic next_outA = loadOut ? txData[1] : outA;
  wire logic next_outB = loadOut ? txData[0] : outB;
  wire logic next_dqOut = goHigh ? next_outA : (goLow ? outB : dqOut);
  wire logic oeCtl = ctrl.oeReq ^ ctrl.inv[ddrpc_pkg::INV_OE];
  wire logic driveReq = ctrl.oeActLow ? ~oeCtl : oeCtl;
  wire logic oeLoad = goLow & ceOut;
  wire logic cellClr = rst | sclrPulse;
  wire logic cellLevel = rst ? 1'b0 : ctrl.initLevel;

  // ----------------------------------------------------------------
  // capture path
  // ----------------------------------------------------------------
  wire logic dqLvl = dqS2 ^ ctrl.inv[ddrpc_pkg::INV_DQ];
  wire logic dqsLvl = dqsS2 ^ ctrl.inv[ddrpc_pkg::INV_DQS];
  wire logic dqsPrev = dqsD ^ ctrl.inv[ddrpc_pkg::INV_DQS];
  wire logic isDq = ctrl.role == ddrpc_pkg::ROLE_DQ;
  wire logic isDqs = ctrl.role == ddrpc_pkg::ROLE_DQS;
  wire logic strobeOk = ctrl.strobeCap & isDq & ~ctrl.sideBank;
  wire logic capRise = strobeOk ? (dqsLvl & ~dqsPrev) : goHigh;
  wire logic capFall = strobeOk ? (~dqsLvl & dqsPrev) : goLow;
  wire logic ceIn = ctrl.inCe ^ ctrl.inv[ddrpc_pkg::INV_CEIN];
  wire logic rxPush = capRise & ceIn & pairReady;
  wire logic ovfSet = rxPush & ~rxInReady;

  assign stat.linkClk = linkClk;
  assign stat.driving = ~dqOeN;
  assign stat.dqsLevel = isDqs & dqsLvl;
  assign stat.dqLevel = dqLvl;
  assign stat.rxCount = rxCount;
  assign stat.txCount = txCount;
  assign stat.overflow = overflow;

  ddrpc_fifo #(.WIDTH(ddrpc_pkg::PAIR_W), .DEPTH(ddrpc_pkg::FIFO_DEPTH)) txBuf (
    .clock(clock),
    .rst(rst),
    .inValid(txPush),
    .inReady(txInReady),
    .inData(hwdata[1:0]),
    .outValid(txOutValid),
    .outReady(loadOut),
    .outData(txData),
    .count(txCount)
  );

  ddrpc_fifo #(.WIDTH(ddrpc_pkg::PAIR_W), .DEPTH(ddrpc_pkg::FIFO_DEPTH)) rxBuf (
    .clock(clock),
    .rst(rst),
    .inValid(rxPush),
    .inReady(rxInReady),
    .inData({heldHigh, fallReg}),
    .outValid(rxOutValid),
    .outReady(rxPop),
    .outData(rxData),
    .count(rxCount)
  );

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    hresp <= 1'b0;
    if (rst) begin
      pending <= 1'b0;
      pendWrite <= 1'b0;
      pendWord <= 1'b0;
      pendAddr <= 8'h00;
      hreadyout <= 1'b1;
      hrdata <= 32'h00000000;
    end else if (addrTake) begin
      pending <= 1'b1;
      pendWrite <= hwrite;
      pendWord <= hsize == ddrpc_pkg::HSIZE_WORD;
      pendAddr <= haddr[7:0];
      hreadyout <= 1'b0;
    end else if (done) begin
      pending <= 1'b0;
      hreadyout <= 1'b1;
      hrdata <= readData;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl <= ddrpc_pkg::CTRL_RESET;
      overflow <= 1'b0;
    end else begin
      if (ctrlWrite) begin
        ctrl <= wctrl;
        ctrl.sclr <= 1'b0;
      end
      // a drop in the clearing cycle keeps the flag
      if (ovfSet) begin
        overflow <= 1'b1;
      end else if (ovfClear) begin
        overflow <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // pin registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      dqS1 <= 1'b0;
      dqS2 <= 1'b0;
      dqsS1 <= 1'b0;
      dqsS2 <= 1'b0;
      dqsD <= 1'b0;
      linkClk <= 1'b0;
    end else begin
      dqS1 <= dqIn;
      dqS2 <= dqS1;
      dqsS1 <= dqsIn;
      dqsS2 <= dqsS1;
      dqsD <= dqsS2;
      linkClk <= ctrl.linkEn & ~linkClk;
    end
  end

  always_ff @(posedge clock) begin
    if (cellClr) begin
      outA <= cellLevel;
      outB <= cellLevel;
      dqOut <= cellLevel;
      dqOeN <= 1'b1;
    end else begin
      outA <= next_outA;
      outB <= next_outB;
      dqOut <= next_dqOut;
      if (oeLoad) begin
        dqOeN <= ~driveReq;
      end
    end
  end

  // the sampled bit is the pin level two cycles before the capture edge
  always_ff @(posedge clock) begin
    if (cellClr) begin
      riseReg <= cellLevel;
      fallReg <= cellLevel;
      heldHigh <= cellLevel;
      pairReady <= 1'b0;
    end else if (ceIn) begin
      if (capRise) begin
        riseReg <= dqLvl;
        pairReady <= 1'b0;
      end else if (capFall) begin
        fallReg <= dqLvl;
        heldHigh <= riseReg;
        pairReady <= 1'b1;
      end
    end
  end
endmodule

`default_nettype wire

// File: logic/ddrpc_pkg.sv
// Purpose: shared constants and types of the ddr pin cell
// Assumes: 32-bit ahb-lite register bus, one 40 MHz clock
// Notes: register offsets are byte addresses
package ddrpc_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_TX = 8'h04;
  localparam logic [7:0] ADDR_RX = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0C;
  localparam logic [15:0] CTRL_RESET = 16'h000C;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // ----------------------------------------------------------------
  // field layouts
  // ----------------------------------------------------------------
  localparam int INV_DQ = 0;
  localparam int INV_DQS = 1;
  localparam int INV_CEIN = 2;
  localparam int INV_CEOUT = 3;
  localparam int INV_OE = 4;
  localparam int FIFO_DEPTH = 2;
  localparam int PAIR_W = 2;

  typedef enum logic [1:0] {ROLE_GPIO, ROLE_DQ, ROLE_DQS} ddrpc_role_e;

  // bit 15 down to bit 0
  typedef struct packed {
    logic [1:0] role;
    logic sclr;
    logic [4:0] inv;
    logic initLevel;
    logic strobeCap;
    logic sideBank;
    logic oeActLow;
    logic inCe;
    logic outCe;
    logic oeReq;
    logic linkEn;
  } ddrpc_ctrl_s;

  // bit 8 down to bit 0
  typedef struct packed {
    logic linkClk;
    logic driving;
    logic dqsLevel;
    logic dqLevel;
    logic [1:0] rxCount;
    logic [1:0] txCount;
    logic overflow;
  } ddrpc_stat_s;
endpackage

// File: testbench/ddrpc_properties.sv
// Purpose: port-level properties of the pin cell
// Assumes: one clock domain, rst synchronous high
// Notes: bound to every pin cell instance
`timescale 1ns/1ps
`default_nettype none
module ddrpc_properties (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // pins
  input wire logic dqOut,
  input wire logic dqOeN,
  input wire logic linkClk
);
  // --------
  // checks
  // --------
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence read_s;
    hsel && hready && htrans == ddrpc_pkg::HTRANS_NONSEQ && !hwrite;
  endsequence
  sequence one_wait_s;
    !hreadyout ##1 hreadyout;
  endsequence
  bus_wait_a: assert property (read_s |=> one_wait_s)
    else $error("read wait state wrong");
  bus_okay_a: assert property (!hresp)
    else $error("error response");
  rdata_hold_a: assert property ($changed(hrdata) |-> $rose(hreadyout))
    else $error("read data moved");
  read_upper_a: assert property (read_s |-> ##2 hrdata[31:16] == 16'h0000)
    else $error("upper read bits set");
  link_phase_a: assert property (linkClk |=> !linkClk)
    else $error("link high two cycles");
  oe_fall_a: assert property ($fell(dqOeN) |-> $fell(linkClk))
    else $error("driver on off falling edge");
  // link running: the data moves only together with a link edge
  launch_edge_a: assert property ($changed(dqOut) && $past(linkClk, 2) != $past(linkClk)
    |-> $changed(linkClk))
    else $error("data moved off link edge");
  reset_state_a: assert property ($fell(rst) |-> dqOeN && !linkClk && hreadyout)
    else $error("reset state wrong");
endmodule
bind ddrpc_pin_cell ddrpc_properties i_props (.clock(clock), .rst(rst), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .hrdata(hrdata), .dqOut(dqOut), .dqOeN(dqOeN), .linkClk(linkClk));
`default_nettype wire

// File: testbench/ddrpc_mem_model.sv
// Purpose: memory side of the dq pin
// Assumes: one bit per link phase
// Notes: strobe follows the data bit in mode 3, otherwise held low
`timescale 1ns/1ps
`default_nettype none
module ddrpc_mem_model (
  // pins
  input wire logic clock,
  input wire logic dqOut,
  input wire logic dqOeN,
  input wire logic [1:0] mode,
  output logic dqIn,
  output logic dqsIn
);
  logic drv = 1'b0;
  // bit changes once a cycle, stable across each capture edge
  always @(posedge clock) begin
    drv <= mode[1] ? ~drv : mode[0];
  end
  assign dqIn = dqOeN ? drv : dqOut;
  // in mode 3 each strobe edge rides with its own bit, so strobe capture is checkable
  assign dqsIn = (mode == 2'h3) ? drv : 1'b0;
endmodule
`default_nettype wire

// File: testbench/ddrpc_pin_cell_tb.sv
// Purpose: self-checking bench of the pin cell
// Assumes: one bus master, memory model on the pin
// Notes: pair patterns chosen so alignment needs no guess
`timescale 1ns/1ps
`default_nettype none
module ddrpc_pin_cell_tb;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b1;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [1:0] mode = 2'h1;
  wire logic hreadyout, hresp, dqIn, dqOut, dqOeN, dqsIn, linkClk;
  wire logic [31:0] hrdata;
  int n_mismatch = 0;
  int compares = 0;
  logic [31:0] d;
  always #12.5 clock = ~clock;
  ddrpc_pin_cell i_dut (.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .dqIn(dqIn), .dqOut(dqOut),
    .dqOeN(dqOeN), .dqsIn(dqsIn), .linkClk(linkClk));
  ddrpc_mem_model i_mem (.clock(clock), .dqOut(dqOut), .dqOeN(dqOeN), .mode(mode),
    .dqIn(dqIn), .dqsIn(dqsIn));
  // --------
  // helpers
  // --------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s seen %h", $time, msg, seen);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    haddr <= {24'h0, a};
    htrans <= ddrpc_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clock); while (hreadyout !== 1'b1);
    d = hrdata;
  endtask
  task automatic pat(input logic flip, input string msg);
    repeat (8) begin
      @(negedge clock);
      chk(32'(dqOut), 32'(linkClk ^ flip), msg);
    end
    @(posedge clock);
  endtask
  task automatic grab(input logic [31:0] ctrl);
    bus(1'b1, ddrpc_pkg::ADDR_CTRL, ctrl);
    repeat (4) bus(1'b0, ddrpc_pkg::ADDR_RX, 32'h0);
    repeat (12) @(posedge clock);
    bus(1'b0, ddrpc_pkg::ADDR_RX, 32'h0);
  endtask
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // --------
  // scenarios
  // --------
  task automatic t_reset;
    chk(32'({dqOeN, dqOut, linkClk}), 32'h4, "pins after reset");
    bus(1'b0, ddrpc_pkg::ADDR_CTRL, 32'h0);
    chk(d, 32'(ddrpc_pkg::CTRL_RESET), "ctrl reset");
    bus(1'b1, 8'h10, 32'hFFFFFFFF);
    bus(1'b0, 8'h10, 32'h0);
    chk(d, 32'h0, "unmapped");
    $display("reset test done");
  endtask
  task automatic t_launch;
    bus(1'b1, ddrpc_pkg::ADDR_CTRL, 32'h0000000D);
    bus(1'b1, ddrpc_pkg::ADDR_TX, 32'h2);
    repeat (8) @(posedge clock);
    pat(1'b0, "pair 10");
    bus(1'b1, ddrpc_pkg::ADDR_TX, 32'h1);
    repeat (8) @(posedge clock);
    pat(1'b1, "pair 01");
    $display("launch test done");
  endtask
  task automatic t_hold;
    // output enable low: new pair and drive request both wait
    bus(1'b1, ddrpc_pkg::ADDR_CTRL, 32'h0000000B);
    bus(1'b1, ddrpc_pkg::ADDR_TX, 32'h2);
    repeat (8) @(posedge clock);
    pat(1'b1, "held pair");
    chk(32'(dqOeN), 32'h1, "oe held");
    bus(1'b1, ddrpc_pkg::ADDR_CTRL, 32'h0000000F);
    repeat (8) @(posedge clock);
    pat(1'b0, "released pair");
    chk(32'(dqOeN), 32'h0, "oe driving");
    // inverted output enable: a low enable bit now lets the pair load
    bus(1'b1, ddrpc_pkg::ADDR_CTRL, 32'h0000080B);
    bus(1'b1, ddrpc_pkg::ADDR_TX, 32'h1);
    repeat (8) @(posedge clock);
    pat(1'b1, "inverted out enable");
    $display("hold test done");
  endtask
  task automatic t_polar;
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, ddrpc_pkg::ADDR_CTRL,
        32'hD | 32'(i[0]) << 1 | 32'(i[1]) << 4 | 32'(i[2]) << 12);
      repeat (4) @(posedge clock);
      chk(32'(dqOeN), 32'(~^i[2:0]), "oe polarity");
    end
    $display("polarity test done");
  endtask
  task automatic t_clear;
    // clear uses the level held before the write that carries it
    bus(1'b1, ddrpc_pkg::ADDR_CTRL, 32'h0000008C);
    bus(1'b1, ddrpc_pkg::ADDR_CTRL, 32'h0000200C);
    chk(32'({dqOeN, dqOut, linkClk}), 32'h6, "clear to high");
    bus(1'b1, ddrpc_pkg::ADDR_CTRL, 32'h0000200C);
    chk(32'({dqOeN, dqOut, linkClk}), 32'h4, "clear to low");
    bus(1'b0, ddrpc_pkg::ADDR_CTRL, 32'h0);
    chk(d, 32'h0000000C, "clear bit reads zero");
    $display("clear test done");
  endtask
  task automatic t_capture;
    grab(32'h0000406D);
    chk(32'(d[8:0]), 32'h103, "ones side bank");
    bus(1'b0, ddrpc_pkg::ADDR_STAT, 32'h0);
    chk(32'({d[4:3], d[0]}), 32'h5, "rx full and dropped");
    grab(32'h0000416D);
    chk(32'(d[8:0]), 32'h100, "inverted dq");
    mode <= 2'h2;
    grab(32'h0000406D);
    chk(32'(d[8] & (d[1] ^ d[0])), 32'h1, "alternating");
    grab(32'h0000404D);
    chk(32'(d[8]), 32'h0, "strobe only");
    // no capture runs now, so the drop flag clears and stays clear
    bus(1'b1, ddrpc_pkg::ADDR_STAT, 32'h1);
    bus(1'b0, ddrpc_pkg::ADDR_STAT, 32'h0);
    chk(32'(d[4:0]), 32'h0, "drop flag cleared");
    mode <= 2'h3;
    grab(32'h0000404D);
    chk(32'(d[8:0]), 32'h102, "strobe pairs");
    $display("capture test done");
  endtask
  initial begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    t_reset;
    t_launch;
    t_hold;
    t_polar;
    t_clear;
    t_capture;
    wrap_up;
  end
  initial begin
    repeat (5000) @(posedge clock);
    n_mismatch++;
    wrap_up;
  end
endmodule
`default_nettype wire
